/* File: src/vsw_pkg.sv */
// Package: register map, field layout and reset values of the video switch control block.
// Assumes a single 40 MHz clock domain; I2C pins are sampled as synchronous inputs.
package vsw_pkg;
    localparam logic [1:0] PTR_SINK1       = 2'h1;
    localparam logic [1:0] PTR_SINK2       = 2'h2;
    localparam logic [1:0] PTR_STATUS      = 2'h3;
    localparam logic [7:0] PTR_RESET       = 8'h03;
    localparam logic [7:0] SINK1_RESET     = 8'h08;
    localparam logic [7:0] SINK2_RESET     = 8'h09;
    localparam logic [7:0] STATUS_RESET    = 8'h10;
    localparam logic [4:0] ADDR_FIXED      = 5'h0b;
    localparam int         CFG_DEEMPH_BIT  = 4;
    localparam int         CFG_DDC_EN_BIT  = 3;
    localparam int         CFG_OUT_DIS_BIT = 2;
    localparam int         ST_PRIO_BIT     = 5;
    localparam int         ST_GATE_BIT     = 4;
    localparam logic [7:0] CFG_RW_MASK     = 8'h1f;
    localparam logic [7:0] ST_RW_MASK      = 8'h30;
    localparam logic [7:0] PTR_RW_MASK     = 8'h03;
    localparam logic [3:0] BIT_LAST        = 4'h7;
    localparam logic [3:0] BIT_ACK         = 4'h8;
    localparam int         NUM_SRC         = 4;
    localparam int         CLK_HZ          = 40000000;
    localparam int         FAST_SCL_HZ     = 400000;
    localparam int         SCL_HALF_CYC    = CLK_HZ / FAST_SCL_HZ / 2;
endpackage

/* File: src/vsw_i2c_ctrl.sv */
// I2C slave register block and port routing control of a 4-to-2 video switch.
// Assumes SCL and SDA are synchronous to i_ref_clk and pulled up outside.
// Function
// - Shared source drives both sinks; DDC and hot plug follow priority sink.
// - Gating on and source unpowered: sink outputs Z, hot plug low.
// - Pointer upper bits zero; low bits pick sink1, sink2 or status.
// - Pointer resets to select the status register.
// - Sink1 config: deemph, DDC enable, out disable, select; resets 0x08.
// - Sink2 config same layout, resets to 0x09.
// - Status: priority, gating enable, four power bits; resets 0x10.
// - Slave only, standard and fast mode rates.
// - Start condition detected at any time.
// - Matching address acked on ninth clock; otherwise silent.
// - Slave acks address, pointer and first data byte, not later bytes; transmitter releases SDA in ack slot.
// - Stop releases bus and waits for new start and address.
// - Only one data byte written per transaction.
// - Only one data byte returned per read transaction.
// - Address is fixed 01011 plus two address select pins.
// - Address select pins compared live, never latched.
// - Direction zero is write, one is read.
// - First write byte loads pointer, next byte writes the register.
// - Select codes 00 to 11 route sources 1 to 4.
// - Output disable sets TMDS Z; DDC enable clear sets DDC Z.
module vsw_i2c_ctrl
    import vsw_pkg::*;
#(
    parameter int SINK_COUNT = 2,
    parameter int SRC_COUNT  = NUM_SRC
)
(
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_rst,
    input  wire logic                 i_scl,
    input  wire logic                 i_sda,
    output logic                      o_sda,
    output logic                      o_sda_oe,
    input  wire logic                 i_addr_select_hi,
    input  wire logic                 i_addr_select_lo,
    input  wire logic [NUM_SRC-1:0]   i_source_power_present,
    input  wire logic [1:0]           i_sink_hot_plug_in,
    output logic [1:0]                o_sink_tmds_enable,
    output logic [3:0]                o_sink_tmds_source,
    output logic [1:0]                o_sink_ddc_enable,
    output logic [1:0]                o_sink_deemphasis,
    output logic [NUM_SRC-1:0]        o_hot_plug_out,
    output logic [NUM_SRC-1:0]        o_source_ddc_enable,
    output logic [NUM_SRC-1:0]        o_source_ddc_sink,
    output logic [7:0]                o_register_pointer,
    output logic [7:0]                o_sink1_config,
    output logic [7:0]                o_sink2_config,
    output logic [7:0]                o_source_plug_status
);
    import vsw_pkg::*;

    // Routing serves exactly two sinks; the status word holds four power bits
    if (SINK_COUNT != 2) begin : g_sink_check
        $error("vsw_i2c_ctrl: only two sinks are supported");
    end
    if (SRC_COUNT != NUM_SRC) begin : g_src_check
        $error("vsw_i2c_ctrl: only four sources are supported");
    end

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR_BYTE, ST_WR_ACK, ST_RD_BYTE, ST_RD_ACK, ST_IGNORE
    } vsw_state_type;

    vsw_state_type state_ff;
    logic       scl_ff;
    logic       sda_ff;
    logic [3:0] bit_cnt_ff;
    logic [7:0] shift_ff;
    logic       rd_ff;
    logic       ack_drive_ff;
    logic       match_ff;
    logic       data_phase_ff;
    logic [7:0] ptr_ff;
    logic [7:0] sink1_ff;
    logic [7:0] sink2_ff;
    logic [1:0] st_ctrl_ff;
    logic       sda_out_ff;
    logic       sda_oe_ff;

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic addr_hit;
    logic [7:0] status_val;
    logic [7:0] rd_val;
    logic [6:0] own_addr;
    logic [2:0] rd_idx;
    logic       byte_done;
    logic       rd_load;
    logic       wr_strobe;

    // Pointed register value, reserved bits forced low
    function automatic logic [7:0] sel_reg(input logic [1:0] sel, input logic [7:0] c1,
                                           input logic [7:0] c2, input logic [7:0] st);
        logic [7:0] r;
        r = 8'h00;
        case (sel)
            PTR_SINK1:  r = c1 & CFG_RW_MASK;
            PTR_SINK2:  r = c2 & CFG_RW_MASK;
            PTR_STATUS: r = st;
            default:    r = 8'h00;
        endcase
        return r;
    endfunction

    // Configuration register of one sink
    function automatic logic [7:0] sink_cfg(input int s, input logic [7:0] c1,
                                            input logic [7:0] c2);
        return (s == 0) ? c1 : c2;
    endfunction

    assign scl_rise  = i_scl & ~scl_ff;
    assign scl_fall  = ~i_scl & scl_ff;
    assign start_det = scl_ff & i_scl & sda_ff & ~i_sda;
    assign stop_det  = scl_ff & i_scl & ~sda_ff & i_sda;
    assign own_addr  = {ADDR_FIXED, i_addr_select_hi, i_addr_select_lo};
    assign addr_hit  = shift_ff[7:1] == own_addr;
    assign rd_idx    = 3'(BIT_LAST - 4'(bit_cnt_ff + 4'h1));
    assign byte_done = scl_fall && bit_cnt_ff == BIT_ACK;
    assign rd_load   = state_ff == ST_ADDR_ACK && rd_ff && scl_fall;
    assign wr_strobe = state_ff == ST_WR_ACK && scl_fall && !start_det && !stop_det;
    assign status_val = {2'h0, st_ctrl_ff, i_source_power_present};
    assign rd_val    = sel_reg(ptr_ff[1:0], sink1_ff, sink2_ff, status_val);

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            scl_ff <= 1'b1;
            sda_ff <= 1'b1;
        end else begin
            scl_ff <= i_scl;
            sda_ff <= i_sda;
        end
    end

    // Bit-level protocol engine, sampling on SCL rise and acting on SCL fall
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            state_ff      <= ST_IDLE;
            bit_cnt_ff    <= 4'h0;
            shift_ff      <= 8'h00;
            rd_ff         <= 1'b0;
            ack_drive_ff  <= 1'b0;
            match_ff      <= 1'b0;
            data_phase_ff <= 1'b0;
        end else if (start_det) begin
            state_ff      <= ST_ADDR;
            bit_cnt_ff    <= 4'h0;
            data_phase_ff <= 1'b0;
            ack_drive_ff  <= 1'b0;
        end else if (stop_det) begin
            state_ff     <= ST_IDLE;
            ack_drive_ff <= 1'b0;
        end else begin
            case (state_ff)
                ST_ADDR, ST_WR_BYTE: begin
                    if (scl_rise) begin
                        shift_ff   <= {shift_ff[6:0], i_sda};
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end else if (byte_done) begin
                        if (state_ff == ST_ADDR) begin
                            rd_ff        <= shift_ff[0];
                            match_ff     <= addr_hit;
                            ack_drive_ff <= addr_hit;
                            state_ff     <= addr_hit ? ST_ADDR_ACK : ST_IGNORE;
                        end else begin
                            ack_drive_ff <= 1'b1;
                            state_ff     <= ST_WR_ACK;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        ack_drive_ff <= 1'b0;
                        bit_cnt_ff   <= 4'h0;
                        state_ff     <= rd_ff ? ST_RD_BYTE : ST_WR_BYTE;
                    end
                end
                ST_WR_ACK: begin
                    if (scl_fall) begin
                        ack_drive_ff  <= 1'b0;
                        bit_cnt_ff    <= 4'h0;
                        data_phase_ff <= 1'b1;
                        state_ff      <= data_phase_ff ? ST_IGNORE : ST_WR_BYTE;
                    end
                end
                ST_RD_BYTE: begin
                    if (scl_fall) begin
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                        if (bit_cnt_ff == BIT_LAST) begin
                            state_ff <= ST_RD_ACK;
                        end
                    end
                end
                ST_RD_ACK: begin
                    if (scl_fall) begin
                        state_ff <= ST_IGNORE;
                    end
                end
                ST_IGNORE: begin
                    state_ff <= ST_IGNORE;
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // Read shifter drives SDA after each SCL fall; released in ack slot
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            sda_out_ff <= 1'b1;
            sda_oe_ff  <= 1'b0;
        end else if (start_det || stop_det) begin
            sda_out_ff <= 1'b1;
            sda_oe_ff  <= 1'b0;
        end else if (rd_load) begin
            sda_out_ff <= rd_val[7];
            sda_oe_ff  <= ~rd_val[7];
        end else if (state_ff == ST_RD_BYTE && scl_fall) begin
            if (bit_cnt_ff == BIT_LAST) begin
                sda_out_ff <= 1'b1;
                sda_oe_ff  <= 1'b0;
            end else begin
                sda_out_ff <= rd_val[rd_idx];
                sda_oe_ff  <= ~rd_val[rd_idx];
            end
        end else if (ack_drive_ff) begin
            sda_out_ff <= 1'b0;
            sda_oe_ff  <= 1'b1;
        end else if (state_ff != ST_RD_BYTE) begin
            sda_out_ff <= 1'b1;
            sda_oe_ff  <= 1'b0;
        end
    end

    // Register writes on the ack fall of the pointer byte and the first data byte
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            ptr_ff     <= PTR_RESET;
            sink1_ff   <= SINK1_RESET;
            sink2_ff   <= SINK2_RESET;
            st_ctrl_ff <= STATUS_RESET[ST_PRIO_BIT:ST_GATE_BIT];
        end else if (wr_strobe) begin
            if (!data_phase_ff) begin
                ptr_ff <= shift_ff & PTR_RW_MASK;
            end else begin
                case (ptr_ff[1:0])
                    PTR_SINK1:  sink1_ff <= shift_ff & CFG_RW_MASK;
                    PTR_SINK2:  sink2_ff <= shift_ff & CFG_RW_MASK;
                    PTR_STATUS: st_ctrl_ff <= shift_ff[ST_PRIO_BIT:ST_GATE_BIT];
                    default:    ptr_ff <= ptr_ff;
                endcase
            end
        end
    end

    // Routing of TMDS, DDC and hot plug per sink
    always_comb begin
        logic [1:0] sel;
        logic       pwr_ok;
        logic       prio_sink;
        logic [7:0] cfg;
        o_sink_tmds_enable  = 2'h0;
        o_sink_ddc_enable   = 2'h0;
        o_hot_plug_out      = '0;
        o_source_ddc_enable = '0;
        o_source_ddc_sink   = '0;
        sel = 2'h0;
        pwr_ok = 1'b0;
        cfg = 8'h00;
        prio_sink = st_ctrl_ff[ST_PRIO_BIT-ST_GATE_BIT];
        for (int s = 0; s < SINK_COUNT; s++) begin
            cfg = sink_cfg(s, sink1_ff, sink2_ff);
            sel = cfg[1:0];
            pwr_ok = ~st_ctrl_ff[0] | i_source_power_present[sel];
            o_sink_tmds_enable[s] = pwr_ok & ~cfg[CFG_OUT_DIS_BIT];
            o_sink_ddc_enable[s] = pwr_ok & cfg[CFG_DDC_EN_BIT];
            if (sink1_ff[1:0] == sink2_ff[1:0] && (s != 32'(prio_sink))) begin
                o_sink_ddc_enable[s] = 1'b0;
            end
            if (pwr_ok && (sink1_ff[1:0] != sink2_ff[1:0] || s == 32'(prio_sink))) begin
                o_hot_plug_out[sel]      = i_sink_hot_plug_in[s];
                o_source_ddc_enable[sel] = o_sink_ddc_enable[s];
                o_source_ddc_sink[sel]   = (s == 1);
            end
        end
    end

    assign o_sda                = sda_out_ff;
    assign o_sda_oe             = sda_oe_ff;
    assign o_sink_tmds_source   = {sink2_ff[1:0], sink1_ff[1:0]};
    assign o_sink_deemphasis    = {sink2_ff[CFG_DEEMPH_BIT], sink1_ff[CFG_DEEMPH_BIT]};
    assign o_register_pointer   = ptr_ff;
    assign o_sink1_config       = sink1_ff & CFG_RW_MASK;
    assign o_sink2_config       = sink2_ff & CFG_RW_MASK;
    assign o_source_plug_status = status_val;
endmodule

/* File: tb/vsw_chk_properties.sv */
// Checker: bus timing and register relations at the control block ports.
// Assumes it is bound to vsw_i2c_ctrl, one clock domain.
module vsw_chk
    import vsw_pkg::*;
(
    input wire logic       i_ref_clk,
    input wire logic       i_rst,
    input wire logic       i_scl,
    input wire logic       o_sda_oe,
    input wire logic [1:0] o_sink_tmds_enable,
    input wire logic [3:0] o_sink_tmds_source,
    input wire logic [1:0] o_sink_ddc_enable,
    input wire logic [3:0] o_source_ddc_enable,
    input wire logic [3:0] o_source_ddc_sink,
    input wire logic [7:0] o_register_pointer,
    input wire logic [7:0] o_sink1_config,
    input wire logic [7:0] o_sink2_config,
    input wire logic [7:0] o_source_plug_status
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    sequence s_ack_high;
        o_sda_oe && $rose(i_scl);
    endsequence
    sequence s_ack_held;
        o_sda_oe [*8];
    endsequence
    AST_RST_VAL: assert property (disable iff (1'b0) i_rst |->
        o_register_pointer == PTR_RESET && o_sink1_config == SINK1_RESET
        && o_sink2_config == SINK2_RESET && o_source_plug_status[7:4] == 4'h1 && !o_sda_oe)
        else $error("reset values wrong");
    AST_RSV_ZERO: assert property (o_register_pointer[7:2] == 6'h0
        && o_sink1_config[7:5] == 3'h0 && o_sink2_config[7:5] == 3'h0
        && o_source_plug_status[7:6] == 2'h0) else $error("reserved bits set");
    AST_SDA_EDGE: assert property ($changed(o_sda_oe) |-> !i_scl)
        else $error("sda drive changed while scl high");
    AST_ACK_HOLD: assert property (s_ack_high |-> s_ack_held)
        else $error("sda drive dropped in high phase");
    AST_OUT_DIS: assert property (o_sink1_config[2] |-> !o_sink_tmds_enable[0])
        else $error("tmds driven while disabled");
    AST_DDC_DIS: assert property (!o_sink2_config[3] |-> !o_sink_ddc_enable[1])
        else $error("ddc driven while disabled");
    AST_GATE: assert property ($stable(o_source_plug_status) && o_source_plug_status[4]
        && !o_source_plug_status[o_sink1_config[1:0]] |-> o_sink_tmds_enable[0] == 1'b0
        && o_sink_ddc_enable[0] == 1'b0) else $error("unpowered source routed");
    AST_SRC_SEL: assert property ($stable(o_sink1_config) && $stable(o_sink2_config)
        |-> o_sink_tmds_source == {o_sink2_config[1:0], o_sink1_config[1:0]})
        else $error("source select not routed");
    AST_PRIO: assert property (o_sink1_config[3:0] == 4'h8 && o_sink2_config[3:0] == 4'h8
        && !o_source_plug_status[4] |-> o_source_ddc_enable[0]
        && o_source_ddc_sink[0] == o_source_plug_status[5]) else $error("ddc owner wrong");
endmodule
bind vsw_i2c_ctrl vsw_chk vsw_chk_i (.*);

/* File: tb/vsw_i2c_master.sv */
// I2C master model driving SCL and pulling SDA low.
// Assumes pull-ups on both lines; SCL stands high between frames.
module vsw_i2c_master
    import vsw_pkg::*;
(
    input  wire logic i_ref_clk,
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_low
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask
    task automatic start();
        o_sda_low = 1'b1;
        w(SCL_HALF_CYC);
        o_scl = 1'b0;
        w(4);
    endtask
    task automatic stop();
        o_sda_low = 1'b1;
        w(SCL_HALF_CYC);
        o_scl = 1'b1;
        w(SCL_HALF_CYC);
        o_sda_low = 1'b0;
        w(SCL_HALF_CYC);
    endtask
    task automatic xbyte(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            o_sda_low = !d[i];
            w(SCL_HALF_CYC);
            o_scl = 1'b1;
            w(SCL_HALF_CYC / 2);
            q[i] = i_sda;
            w(SCL_HALF_CYC / 2);
            o_scl = 1'b0;
            w(4);
        end
    endtask
endmodule

/* File: tb/tb.sv */
// Testbench: register traffic over I2C and port routing checks.
// Assumes the master model and the checker are compiled with it.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import vsw_pkg::*;
    logic       clk = 1'b0, rst = 1'b0, a1 = 1'b0, a0 = 1'b0, ml, scl, sdo, oe;
    logic [3:0] pw = 4'h0, so, hp, se, ds, ak;
    logic [1:0] hin = 2'h0, te, de, dm;
    logic [7:0] ptr, c1, c2, st, q8, q2;
    logic [7:0] e1 = SINK1_RESET, e2 = SINK2_RESET, es = STATUS_RESET;
    logic [8:0] q;
    int         err_total = 0, tests_run = 0, cyc = 0;
    wire logic  sda = (oe ? sdo : 1'b1) && !ml;
    always #12.5 clk = ~clk;
    always @(posedge clk) if (++cyc > 90000) begin
        err_total++;
        finish_test();
    end
    vsw_i2c_ctrl vsw_i2c_ctrl_i (.i_ref_clk(clk), .i_rst(rst), .i_scl(scl), .i_sda(sda),
        .o_sda(sdo), .o_sda_oe(oe), .i_addr_select_hi(a1), .i_addr_select_lo(a0),
        .i_source_power_present(pw), .i_sink_hot_plug_in(hin), .o_sink_tmds_enable(te),
        .o_sink_tmds_source(so), .o_sink_ddc_enable(de), .o_sink_deemphasis(dm),
        .o_hot_plug_out(hp), .o_source_ddc_enable(se), .o_source_ddc_sink(ds),
        .o_register_pointer(ptr), .o_sink1_config(c1), .o_sink2_config(c2),
        .o_source_plug_status(st));
    vsw_i2c_master vsw_i2c_master_i (.i_ref_clk(clk), .i_sda(sda), .o_scl(scl),
        .o_sda_low(ml));
    task automatic chk(input string n, input logic [7:0] s, e);
        tests_run++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    function automatic logic [7:0] ad(input logic r);
        return {ADDR_FIXED, a1, a0, r};
    endfunction
    function automatic logic route(input logic [7:0] c, input logic k);
        logic off;
        off = es[4] && !pw[c[1:0]];
        return k ? c[3] && !off : !c[2] && !off;
    endfunction
    function automatic logic ddc(input logic [7:0] c, input logic k);
        return route(c, 1'b1) && !(e1[1:0] == e2[1:0] && es[5] != k);
    endfunction
    task automatic wr(input logic [7:0] a, p, d, input int n);
        vsw_i2c_master_i.start();
        vsw_i2c_master_i.xbyte({a, 1'b1}, q);
        ak[3] = q[0];
        vsw_i2c_master_i.xbyte({p, 1'b1}, q);
        ak[2] = q[0];
        vsw_i2c_master_i.xbyte({d, 1'b1}, q);
        ak[1] = q[0];
        if (n > 1) vsw_i2c_master_i.xbyte({~d, 1'b1}, q);
        ak[0] = q[0];
        vsw_i2c_master_i.stop();
    endtask
    task automatic rd(input logic more);
        vsw_i2c_master_i.start();
        vsw_i2c_master_i.xbyte({ad(1'b1), 1'b1}, q);
        ak[3] = q[0];
        vsw_i2c_master_i.xbyte({8'hff, !more}, q);
        q8 = q[8:1];
        if (more) vsw_i2c_master_i.xbyte(9'h1ff, q);
        q2 = q[8:1];
        vsw_i2c_master_i.stop();
    endtask
    task automatic ports();
        chk("tmds_en", te, {route(e2, 1'b0), route(e1, 1'b0)});
        chk("ddc_en", de, {ddc(e2, 1'b1), ddc(e1, 1'b0)});
        chk("tmds_src", so, {e2[1:0], e1[1:0]});
        chk("deemph", dm, {e2[4], e1[4]});
        chk("sink1", c1, e1);
        chk("sink2", c2, e2);
        chk("status", st, {es[7:4], pw});
    endtask
    initial begin
        logic [7:0] d;
        logic [1:0] r;
        void'($urandom(61));
        #1 rst = 1'b1;
        repeat (8) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        repeat (4) @(negedge clk);
        chk("ptr", ptr, PTR_RESET);
        ports();
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            {a1, a0, hin, pw} = 8'($urandom);
            r = 2'(i % 3 + 1);
            d = 8'($urandom);
            wr(ad(1'b0), {6'h0, r}, d, 1);
            chk("wr_ack", ak[3:1], 3'h0);
            if (r == PTR_SINK1) e1 = d & CFG_RW_MASK;
            if (r == PTR_SINK2) e2 = d & CFG_RW_MASK;
            if (r == PTR_STATUS) es = d & ST_RW_MASK;
            chk("ptr", ptr, {6'h0, r});
            ports();
            rd(1'b0);
            chk("rd_ack", ak[3], 1'b0);
            chk("rd_data", q8, r == PTR_STATUS ? {es[7:4], pw} : r == PTR_SINK1 ? e1 : e2);
        end
        $display("random test done");
        wr(ad(1'b0), 8'hfd, 8'hff, 1);
        e1 = 8'h1f;
        chk("ptr_hi", ptr, 8'h01);
        rd(1'b1);
        chk("rd_first", q8, 8'h1f);
        chk("rd_second", q2, 8'hff);
        wr({ADDR_FIXED, !a1, a0, 1'b0}, 8'h02, 8'h00, 1);
        chk("bad_addr", ak[3], 1'b1);
        d = 8'($urandom);
        wr(ad(1'b0), 8'h02, d, 2);
        e2 = d & CFG_RW_MASK;
        chk("extra_nack", ak[0], 1'b1);
        ports();
        $display("refusal test done");
        wr(ad(1'b0), 8'h01, 8'h08, 1);
        wr(ad(1'b0), 8'h02, 8'h08, 1);
        e1 = 8'h08;
        e2 = 8'h08;
        for (int p = 0; p < 2; p++) begin
            es = {2'h0, p[0], 5'h0};
            wr(ad(1'b0), 8'h03, es, 1);
            chk("ddc_owner", ds[0], p[0]);
            chk("hot_plug", hp[0], hin[p]);
            ports();
        end
        pw = 4'he;
        es = 8'h10;
        wr(ad(1'b0), 8'h03, es, 1);
        chk("hot_plug_gated", hp[0], 1'b0);
        ports();
        $display("routing test done");
        finish_test();
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
endmodule
